// ### rtl/wdc_defines.svh
// Register offsets, field positions and timing constants of the watchdog control block.
`ifndef WDC_DEFINES_SVH
`define WDC_DEFINES_SVH
`define WDC_ADDR_W        4
`define WDC_CTRL_OFF      4'h0
`define WDC_CAUSE_OFF     4'h1
`define WDC_BIT_FLAG      7
`define WDC_BIT_IE        6
`define WDC_BIT_SEL3      5
`define WDC_BIT_UNLOCK    4
`define WDC_BIT_RSTEN     3
`define WDC_BIT_CAUSE     0
`define WDC_CTRL_RESET    8'h00
`define WDC_UNLOCK_CYCLES 3'h4
`define WDC_SEL_MAX       4'h9
`define WDC_BASE_SHIFT    5'h0b
`define WDC_CNT_W         21
`define WDC_OSC_HZ        128000
`define WDC_SYS_HZ        20000000
`define WDC_MIN_TIMEOUT_MS 16
`define WDC_MAX_TIMEOUT_MS 8000
`define WDC_OSC_DIV       (`WDC_SYS_HZ / `WDC_OSC_HZ)
`endif

// ### rtl/wdc_pkg.sv
// Types shared by the watchdog control block.
package wdc_pkg;
  typedef enum logic [1:0] {
    WDC_STOPPED   = 2'h0,
    WDC_IRQ       = 2'h1,
    WDC_IRQ_RESET = 2'h3,
    WDC_RESET     = 2'h2
  } wdc_mode_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wdc_bus_s;
endpackage

// ### rtl/wdc_watchdog.sv
// Watchdog time-out control with register port, unlock window and mode decode.
// What this block does
// - Interrupt request only when interrupt enable and global interrupt enable are set.
// - Fuse unprogrammed: mode decoded from reset enable and interrupt enable.
// - Combined mode: first time-out sets the flag and interrupts, no reset.
// - Vector taken clears interrupt enable and flag, leaving reset mode if reset enable is set, else stopped.
// - Combined mode: unserviced flag at next time-out causes system reset.
// - Fuse programmed forces system reset mode regardless of enable bits.
// - Clearing reset enable or changing select needs unlock bit set.
// - Unlock bit clears itself four system clocks after being written.
// - Reset enable reads and acts as one while reset cause flag is set.
// - Reset enable cannot clear while reset cause flag stays set.
// - Four-bit select: top bit at bit 5, lower bits at 2..0.
// - Codes 0..9 give 2048 doubling to 1048576 oscillator cycles.
// - Nominal periods span 16 ms to 8 s.
// - Counter advances on a 128 kHz oscillator tick, not system clock.
// - Writing one to the flag clears it.
// - Restart instruction clears the counter.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "wdc_defines.svh"
module wdc_watchdog #(
  parameter int unsigned OSC_DIV = `WDC_OSC_DIV
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire wdc_pkg::wdc_bus_s        bus,
  output logic [7:0]                    rdata,
  input  wire logic                     fuse_programmed_n,
  input  wire logic                     global_irq_enable,
  input  wire logic                     vector_taken,
  input  wire logic                     restart,
  input  wire logic                     cause_set,
  output logic                          irq_req,
  output logic                          sys_reset_req,
  output wdc_pkg::wdc_mode_e            mode
);

  // Time-out length in oscillator ticks for a select code.
  function automatic logic [`WDC_CNT_W-1:0] limit_of(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > `WDC_SEL_MAX) ? `WDC_SEL_MAX : sel;
    limit_of = `WDC_CNT_W'(1) << (`WDC_BASE_SHIFT + 5'(s));
  endfunction

  logic        flag_q, flag_d;
  logic        ie_q, ie_d;
  logic        rsten_q, rsten_d;
  logic        unlock_q, unlock_d;
  logic [3:0]  sel_q, sel_d;
  logic [2:0]  ucnt_q, ucnt_d;
  logic        cause_q, cause_d;
  logic [15:0] div_q;
  logic [`WDC_CNT_W-1:0] cnt_q;
  logic [7:0]  rdata_q;
  logic        rst_pulse_q;

  wire wr_ctrl  = bus.wr && (bus.addr == `WDC_CTRL_OFF);
  wire wr_cause = bus.wr && (bus.addr == `WDC_CAUSE_OFF);
  wire [3:0] sel_wr = {bus.wdata[`WDC_BIT_SEL3], bus.wdata[2:0]};
  wire rsten_eff = rsten_q || cause_q;
  wire fuse_on = !fuse_programmed_n;
  wire tick = (div_q == 16'(OSC_DIV - 1));
  wire [`WDC_CNT_W-1:0] limit = limit_of(sel_q);
  wire running = (mode != wdc_pkg::WDC_STOPPED);
  wire timeout = running && tick && (cnt_q == limit - `WDC_CNT_W'(1));
  wire [7:0] ctrl_rd = {flag_q, ie_q, sel_q[3], unlock_q, rsten_eff, sel_q[2:0]};

  assign mode = fuse_on ? wdc_pkg::WDC_RESET :
                wdc_pkg::wdc_mode_e'({rsten_eff, ie_q});

  wire irq_mode = (mode == wdc_pkg::WDC_IRQ) || (mode == wdc_pkg::WDC_IRQ_RESET);
  wire do_reset = timeout && ((mode == wdc_pkg::WDC_RESET) ||
                  ((mode == wdc_pkg::WDC_IRQ_RESET) && flag_q));
  wire set_flag = timeout && irq_mode && !do_reset;

  always_comb
  begin
    flag_d   = flag_q;
    ie_d     = ie_q;
    rsten_d  = rsten_q;
    unlock_d = unlock_q;
    sel_d    = sel_q;
    ucnt_d   = ucnt_q;
    cause_d  = cause_q;
    if (unlock_q)
    begin
      ucnt_d = ucnt_q + 3'h1;
      if (ucnt_q == `WDC_UNLOCK_CYCLES - 3'h1)
      begin
        unlock_d = 1'b0;
      end
    end
    if (wr_ctrl)
    begin
      ie_d = bus.wdata[`WDC_BIT_IE];
      if (bus.wdata[`WDC_BIT_FLAG])
      begin
        flag_d = 1'b0;
      end
      if (bus.wdata[`WDC_BIT_RSTEN])
      begin
        rsten_d = 1'b1;
      end
      else if (unlock_q && !cause_q)
      begin
        rsten_d = 1'b0;
      end
      if (unlock_q)
      begin
        sel_d = sel_wr;
      end
      if (bus.wdata[`WDC_BIT_UNLOCK])
      begin
        unlock_d = 1'b1;
        ucnt_d   = 3'h0;
      end
      else if (unlock_q)
      begin
        unlock_d = 1'b0;
      end
    end
    if (vector_taken)
    begin
      ie_d   = 1'b0;
      flag_d = 1'b0;
    end
    if (set_flag)
    begin
      flag_d = 1'b1;
    end
    if (wr_cause && !bus.wdata[`WDC_BIT_CAUSE])
    begin
      cause_d = 1'b0;
    end
    if (cause_set)
    begin
      cause_d = 1'b1;
    end
    if (fuse_on)
    begin
      rsten_d = 1'b1;
      ie_d    = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      {flag_q, ie_q, unlock_q, rsten_q} <= 4'h0;
      sel_q   <= 4'h0;
      ucnt_q  <= 3'h0;
      cause_q <= 1'b0;
    end
    else
    begin
      flag_q   <= flag_d;
      ie_q     <= ie_d;
      rsten_q  <= rsten_d;
      unlock_q <= unlock_d;
      sel_q    <= sel_d;
      ucnt_q   <= ucnt_d;
      cause_q  <= cause_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      div_q <= 16'h0;
      cnt_q <= '0;
    end
    else
    begin
      div_q <= tick ? 16'h0 : div_q + 16'h1;
      if (restart || !running || timeout)
      begin
        cnt_q <= '0;
      end
      else if (tick)
      begin
        cnt_q <= cnt_q + `WDC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rdata_q     <= `WDC_CTRL_RESET;
      rst_pulse_q <= 1'b0;
    end
    else
    begin
      rst_pulse_q <= do_reset;
      if (bus.rd)
      begin
        rdata_q <= (bus.addr == `WDC_CTRL_OFF) ? ctrl_rd :
                   (bus.addr == `WDC_CAUSE_OFF) ? {7'h0, cause_q} : 8'h00;
      end
      else
      begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign rdata         = rdata_q;
  assign sys_reset_req = rst_pulse_q;
  assign irq_req       = flag_q && ie_q && global_irq_enable;

  a_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_req |-> (ie_q && global_irq_enable && flag_q))
    else $error("interrupt without enables");
  a_unlock_expire: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(unlock_q) |-> ##4 !unlock_q)
    else $error("unlock bit not cleared after four cycles");
  a_cause_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus.rd && (bus.addr == `WDC_CTRL_OFF) && cause_q) |=> rdata[`WDC_BIT_RSTEN])
    else $error("reset enable reads zero with cause set");
  a_fuse_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fuse_on |-> (mode == wdc_pkg::WDC_RESET))
    else $error("fuse did not force reset mode");
  a_first_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timeout && mode == wdc_pkg::WDC_IRQ_RESET && !flag_q && !vector_taken)
      |=> (flag_q && !rst_pulse_q))
    else $error("first combined time-out did not interrupt");
  a_second_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timeout && mode == wdc_pkg::WDC_IRQ_RESET && flag_q) |=> rst_pulse_q)
    else $error("unserviced time-out did not reset");
  a_vector_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (vector_taken && !set_flag) |=> (!flag_q && !ie_q))
    else $error("vector did not clear enable and flag");
  a_locked_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_ctrl && !unlock_q) |=> $stable(sel_q))
    else $error("select changed while locked");
  a_restart_cnt: assert property (@(posedge sys_clk) disable iff (!rst_n)
    restart |=> (cnt_q == '0))
    else $error("restart did not clear counter");

  // Protection of reset enable and select.
  a_locked_rsten: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_ctrl && !unlock_q && rsten_q) |=> rsten_q)
    else $error("reset enable cleared while locked");
  a_cause_rsten: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cause_q && rsten_q) |=> rsten_q)
    else $error("reset enable cleared with cause set");
  a_unlock_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_ctrl && unlock_q) |=> (sel_q == $past(sel_wr)))
    else $error("unlocked write did not update select");
  a_unlock_arm: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_ctrl && bus.wdata[`WDC_BIT_UNLOCK]) |=> unlock_q)
    else $error("unlock bit not set by write");
  a_cause_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cause_set |=> cause_q)
    else $error("cause flag not set");

  // Flag handling and time-out actions.
  a_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    set_flag |=> flag_q)
    else $error("time-out did not set flag");
  a_flag_wclear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_ctrl && bus.wdata[`WDC_BIT_FLAG] && !set_flag) |=> !flag_q)
    else $error("write one did not clear flag");
  a_vector_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (vector_taken && rsten_eff && !wr_ctrl) |=> (mode == wdc_pkg::WDC_RESET))
    else $error("vector did not leave reset mode");
  a_stopped_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == wdc_pkg::WDC_STOPPED) |=> !sys_reset_req)
    else $error("stopped watchdog requested reset");
  a_irq_no_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timeout && (mode == wdc_pkg::WDC_IRQ)) |=> !sys_reset_req)
    else $error("interrupt mode requested reset");
  a_fuse_forces: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fuse_on |=> (rsten_q && !ie_q))
    else $error("fuse did not force enable bits");
  a_reset_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");

  // Register port read data.
  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !bus.rd |=> (rdata == 8'h00))
    else $error("read data not idle");
  a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus.rd && (bus.addr > `WDC_CAUSE_OFF)) |=> (rdata == 8'h00))
    else $error("unmapped read returned data");

  c_irq_mode: cover property (@(posedge sys_clk) disable iff (!rst_n) set_flag);
  c_vector: cover property (@(posedge sys_clk) disable iff (!rst_n)
    vector_taken && flag_q);
  c_fuse_reset: cover property (@(posedge sys_clk) disable iff (!rst_n)
    fuse_on && timeout);
  c_reset: cover property (@(posedge sys_clk) disable iff (!rst_n) do_reset);
  c_unlock_sel: cover property (@(posedge sys_clk) disable iff (!rst_n)
    wr_ctrl && unlock_q && (sel_wr != sel_q));

endmodule

// ### test/wdc_testbench.sv
// Self-checking testbench of the watchdog control block.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module testbench;
  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  wdc_pkg::wdc_bus_s  bus = '0;
  logic [7:0]         rdata;
  logic               fuse_programmed_n = 1'b1;
  logic               global_irq_enable = 1'b0;
  logic               vector_taken = 1'b0;
  logic               restart = 1'b0;
  logic               cause_set = 1'b0;
  logic               irq_req;
  logic               sys_reset_req;
  wdc_pkg::wdc_mode_e mode;
  int                 errors = 0;
  int                 checks = 0;
  int                 rst_seen = 0;
  int                 n;
  logic [31:0]        seed = 32'h0000_85f8;
  logic [7:0]         q[$];
  logic               pend = 1'b0;

  always #25 sys_clk = ~sys_clk;

  wdc_watchdog #(.OSC_DIV(1)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .fuse_programmed_n(fuse_programmed_n), .global_irq_enable(global_irq_enable),
    .vector_taken(vector_taken), .restart(restart), .cause_set(cause_set),
    .irq_req(irq_req), .sys_reset_req(sys_reset_req), .mode(mode));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    q.push_back(e);
    @(posedge sys_clk);
    bus.rd <= 1'b0;
  endtask

  task automatic unlock(input logic [7:0] d);
    wr(4'h0, 8'h18);
    wr(4'h0, d);
  endtask

  task automatic kick;
    @(posedge sys_clk);
    restart <= 1'b1;
    @(posedge sys_clk);
    restart <= 1'b0;
  endtask

  task automatic wait_irq;
    n = 0;
    while (irq_req !== 1'b1 && n < 9000)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic wrap_up;
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Compares each read result with the oldest noted expectation.
  always @(negedge sys_clk)
  begin
    logic [7:0] e;
    if (pend)
    begin
      e = q.pop_front();
      `CHK(rdata, e)
    end
    pend = bus.rd;
  end

  always @(posedge sys_clk)
    if (sys_reset_req === 1'b1) rst_seen++;

  initial
  begin
    repeat (80000) @(posedge sys_clk);
    errors++;
    wrap_up();
  end

  initial
  begin
    logic [7:0] d;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h00);
    @(negedge sys_clk);
    `CHK(mode, wdc_pkg::WDC_STOPPED)
    wr(4'h0, 8'h40);
    @(negedge sys_clk);
    `CHK(mode, wdc_pkg::WDC_IRQ)
    wr(4'h0, 8'h48);
    @(negedge sys_clk);
    `CHK(mode, wdc_pkg::WDC_IRQ_RESET)
    wr(4'h0, 8'h08);
    @(negedge sys_clk);
    `CHK(mode, wdc_pkg::WDC_RESET)
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h08);
    wr(4'h0, 8'h18);
    rd(4'h0, 8'h18);
    repeat (4) @(posedge sys_clk);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h08);
    unlock(8'h00);
    rd(4'h0, 8'h00);
    repeat (3)
    begin
      seed = xs(seed);
      d = seed[7:0] & 8'h27;
      unlock(d);
      rd(4'h0, d);
      wr(4'h7, seed[15:8]);
      rd(4'h0, d);
      rd(4'h7, 8'h00);
    end
    unlock(8'h00);
    @(posedge sys_clk);
    cause_set <= 1'b1;
    @(posedge sys_clk);
    cause_set <= 1'b0;
    rd(4'h0, 8'h08);
    rd(4'h1, 8'h01);
    unlock(8'h00);
    rd(4'h0, 8'h08);
    wr(4'h1, 8'h00);
    unlock(8'h00);
    rd(4'h0, 8'h00);
    global_irq_enable <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      unlock(s[7:0]);
      wr(4'h0, 8'h40 | s[7:0]);
      kick();
      wait_irq();
      `CHK(n > (2048 << s) - 6 && n < (2048 << s) + 6, 1'b1)
      rd(4'h0, 8'hc0 | s[7:0]);
      @(posedge sys_clk);
      global_irq_enable <= 1'b0;
      @(negedge sys_clk);
      `CHK(irq_req, 1'b0)
      @(posedge sys_clk);
      global_irq_enable <= 1'b1;
      wr(4'h0, 8'hc0 | s[7:0]);
      rd(4'h0, 8'h40 | s[7:0]);
    end
    unlock(8'h00);
    wr(4'h0, 8'h48);
    kick();
    wait_irq();
    `CHK(rst_seen, 0)
    rd(4'h0, 8'hc8);
    n = 0;
    while (rst_seen == 0 && n < 2200)
    begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(rst_seen, 1)
    wr(4'h0, 8'hc8);
    kick();
    wait_irq();
    @(posedge sys_clk);
    vector_taken <= 1'b1;
    @(posedge sys_clk);
    vector_taken <= 1'b0;
    rd(4'h0, 8'h08);
    @(negedge sys_clk);
    `CHK(mode, wdc_pkg::WDC_RESET)
    unlock(8'h00);
    @(negedge sys_clk);
    `CHK(mode, wdc_pkg::WDC_STOPPED)
    @(posedge sys_clk);
    fuse_programmed_n <= 1'b0;
    @(negedge sys_clk);
    `CHK(mode, wdc_pkg::WDC_RESET)
    wr(4'h0, 8'h40);
    rd(4'h0, 8'h08);
    wrap_up();
  end
endmodule
